// ==== rtl/davi_map.vh ====
// Purpose: constants for the delta angle / delta velocity integrator
// Assumes: 16-bit register words, byte-style offsets as printed
// Notes: header only, definitions and no logic
`ifndef DAVI_MAP_VH
`define DAVI_MAP_VH
// register offsets (8-bit address)
`define DAVI_X_ANG_LOW 8'h24
`define DAVI_X_ANG_HIGH 8'h26
`define DAVI_Y_ANG_LOW 8'h28
`define DAVI_Y_ANG_HIGH 8'h2a
`define DAVI_Z_ANG_LOW 8'h2c
`define DAVI_Z_ANG_HIGH 8'h2e
`define DAVI_X_VEL_LOW 8'h30
`define DAVI_X_VEL_HIGH 8'h32
`define DAVI_Y_VEL_LOW 8'h34
`define DAVI_Y_VEL_HIGH 8'h36
`define DAVI_Z_VEL_LOW 8'h38
`define DAVI_Z_VEL_HIGH 8'h3a
`define DAVI_DEC_SET 8'h64
// widths and values
`define DAVI_SW 16
`define DAVI_AW 40
`define DAVI_DEC_RST 16'h0000
`define DAVI_ZERO16 16'h0000
`define DAVI_POS_MAX 32'h7fffffff
`define DAVI_NEG_MAX 32'h80000000
// accumulator bits below the output lsb (divide by 2*fs folded into scale)
`define DAVI_FRAC 8
// nominal internal sample rate, samples per second
`define DAVI_FS_SPS 2000
`define DAVI_CLK_HZ 10000000
`define DAVI_SAMPLE_CYC (`DAVI_CLK_HZ / `DAVI_FS_SPS)
`define DAVI_SAMPLE_CYC_W 13
`endif

// ==== rtl/davi_axis.v ====
// Purpose: one axis trapezoidal integrator with saturation to 32 bits
// Assumes: sample_tick one cycle per new sample; dump, sampled only with sample_tick, ends a period
// Notes: result updates whole 32 bits at once
`timescale 1ns/1ns
`default_nettype none
`include "davi_map.vh"
module davi_axis
(
  input wire mclk,
  input wire nrst,
  input wire sample_tick,
  input wire dump,
  input wire signed [15:0] sample,
  output reg [31:0] result
);
// ============================================================
// integration
reg signed [15:0] prev;
reg signed [`DAVI_AW-1:0] acc;
wire signed [`DAVI_AW-1:0] pair_sum;
wire signed [`DAVI_AW-1:0] acc_new;
wire signed [`DAVI_AW-1:0] scaled;
// sample plus predecessor; the 1/(2 fs) factor is a fixed scale
assign pair_sum = {{(`DAVI_AW-16){sample[15]}}, sample} + {{(`DAVI_AW-16){prev[15]}}, prev};
assign acc_new = acc + pair_sum;
assign scaled = acc_new >>> `DAVI_FRAC;
// accumulate, dump at the period boundary and restart
always @(posedge mclk or negedge nrst)
begin
  if (!nrst)
  begin
    prev <= 16'sh0000;
    acc <= {`DAVI_AW{1'b0}};
    result <= 32'h00000000;
  end
  else if (sample_tick)
  begin
    prev <= sample;
    if (dump)
    begin
      acc <= {`DAVI_AW{1'b0}};
      // saturate at the 32-bit ends, both halves move together
      if (scaled > $signed({{(`DAVI_AW-32){1'b0}}, `DAVI_POS_MAX}))
        result <= `DAVI_POS_MAX;
      else if (scaled < $signed({{(`DAVI_AW-32){1'b1}}, `DAVI_NEG_MAX}))
        result <= `DAVI_NEG_MAX;
      else
        result <= scaled[31:0];
    end
    else
      acc <= acc_new;
  end
end
endmodule
`default_nettype wire

// ==== rtl/davi_top.v ====
// Operation
// - velocity per axis sums each accel sample plus predecessor, scaled by 1/(2fs).
// - integration length is decimation setting plus one samples.
// - internal sample clock runs at nominal 2000 samples per second.
// - x angle low word at 0x24, high at 0x26, read-only.
// - y angle low word at 0x28, high at 0x2a, read-only.
// - z angle low word at 0x2c, high at 0x2e, read-only.
// - high angle word twos complement, zero reads 0x0000.
// - 16-bit high word spans 0x8000 to 0x7fff.
// - high plus low form 32-bit twos complement, saturating at ends.
// - each velocity axis has high and low words forming 32 bits.
// - angle per axis uses same trapezoidal sum of rate samples.
// - angle full scale is a variant parameter: 360, 720 or 2160; here ANGLE_RANGE_DEG is declared but not used.
// - velocity high word twos complement over plus or minus 100 m/s.
//
// Purpose: six-axis delta angle and delta velocity registers
// Assumes: gyro and accel samples arrive synchronous to mclk
// Notes: reads are one cycle late, writes only reach the decimation setting
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "davi_map.vh"
module davi_top
#(
  parameter ANGLE_RANGE_DEG = 360
)
(
  input wire mclk,
  input wire nrst,
  input wire ext_sample_en,
  input wire ext_sample_tick,
  input wire [47:0] gyro_samples,
  input wire [47:0] accel_samples,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  output reg sample_ready_pin,
  output reg [15:0] decimation_setting
);
// ============================================================
// sample clock
// internal rate derived from mclk; external tick replaces it when enabled
reg [`DAVI_SAMPLE_CYC_W-1:0] div_cnt;
reg int_tick;
wire sample_tick;
always @(posedge mclk or negedge nrst)
begin
  if (!nrst)
  begin
    div_cnt <= {`DAVI_SAMPLE_CYC_W{1'b0}};
    int_tick <= 1'b0;
  end
  else if (div_cnt == `DAVI_SAMPLE_CYC - 1)
  begin
    div_cnt <= {`DAVI_SAMPLE_CYC_W{1'b0}};
    int_tick <= 1'b1;
  end
  else
  begin
    div_cnt <= div_cnt + 1'b1;
    int_tick <= 1'b0;
  end
end
assign sample_tick = ext_sample_en ? ext_sample_tick : int_tick;
// ============================================================
// decimation period counter
// a new setting takes effect at the next period start, so the running
// period is never cut short
reg [15:0] dec_cnt;
reg [15:0] dec_active;
wire dump;
assign dump = (dec_cnt == dec_active);
always @(posedge mclk or negedge nrst)
begin
  if (!nrst)
  begin
    dec_cnt <= `DAVI_ZERO16;
    dec_active <= `DAVI_DEC_RST;
  end
  else if (sample_tick)
  begin
    if (dump)
    begin
      dec_cnt <= `DAVI_ZERO16;
      dec_active <= decimation_setting;
    end
    else
      dec_cnt <= dec_cnt + 1'b1;
  end
end
// data ready pulse, raised at the same edge the results load
always @(posedge mclk or negedge nrst)
begin
  if (!nrst)
    sample_ready_pin <= 1'b0;
  else
    sample_ready_pin <= sample_tick & dump;
end
// ============================================================
// integrators, one per axis per quantity
// index 0..2 angle x,y,z; 3..5 velocity x,y,z
wire [31:0] results [0:5];
wire [95:0] all_samples;
assign all_samples = {accel_samples, gyro_samples};
genvar gi;
generate
  for (gi = 0; gi < 6; gi = gi + 1)
  begin : g_axis
    davi_axis u_axis
    (
      .mclk(mclk),
      .nrst(nrst),
      .sample_tick(sample_tick),
      .dump(dump),
      .sample(all_samples[gi*16 +: 16]),
      .result(results[gi])
    );
  end
endgenerate
// ============================================================
// register write: only the decimation setting is writable
always @(posedge mclk or negedge nrst)
begin
  if (!nrst)
    decimation_setting <= `DAVI_DEC_RST;
  else if (reg_wr && reg_addr == `DAVI_DEC_SET)
    decimation_setting <= reg_wdata;
end
// ============================================================
// register read mux; output words are read-only, writes to them ignored
// raw 32-bit twos complement, high word on top
reg [15:0] next_rdata;
always @*
begin
  next_rdata = `DAVI_ZERO16;
  case (reg_addr)
    `DAVI_X_ANG_LOW: next_rdata = results[0][15:0];
    `DAVI_X_ANG_HIGH: next_rdata = results[0][31:16];
    `DAVI_Y_ANG_LOW: next_rdata = results[1][15:0];
    `DAVI_Y_ANG_HIGH: next_rdata = results[1][31:16];
    `DAVI_Z_ANG_LOW: next_rdata = results[2][15:0];
    `DAVI_Z_ANG_HIGH: next_rdata = results[2][31:16];
    `DAVI_X_VEL_LOW: next_rdata = results[3][15:0];
    `DAVI_X_VEL_HIGH: next_rdata = results[3][31:16];
    `DAVI_Y_VEL_LOW: next_rdata = results[4][15:0];
    `DAVI_Y_VEL_HIGH: next_rdata = results[4][31:16];
    `DAVI_Z_VEL_LOW: next_rdata = results[5][15:0];
    `DAVI_Z_VEL_HIGH: next_rdata = results[5][31:16];
    `DAVI_DEC_SET: next_rdata = decimation_setting;
    default: next_rdata = `DAVI_ZERO16;
  endcase
end
// read data stands only in the cycle after the strobe
always @(posedge mclk or negedge nrst)
begin
  if (!nrst)
    reg_rdata <= `DAVI_ZERO16;
  else if (reg_rd)
    reg_rdata <= next_rdata;
  else
    reg_rdata <= `DAVI_ZERO16;
end
endmodule
`default_nettype wire

// ==== tb/davi_chk.sv ====
// Purpose: port assertions for davi_top
// Assumes: external ticks at least six cycles apart
// Notes: bound at the foot
`timescale 1ns/1ns
`default_nettype none
module davi_chk
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ext_sample_en,
  input wire logic ext_sample_tick,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic sample_ready_pin,
  input wire logic [15:0] decimation_setting
);
  // ==========
  // one clock domain, so checks are quiet while reset holds
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not idle");
  a_ready_single: assert property (sample_ready_pin |=> !sample_ready_pin)
    else $error("ready pulse too long");
  a_dec_write: assert property (reg_wr && reg_addr == 8'h64 |=> decimation_setting == $past(reg_wdata))
    else $error("setting not written");
  a_dec_hold: assert property (!(reg_wr && reg_addr == 8'h64) |=> $stable(decimation_setting))
    else $error("setting moved");
  a_ro_write: assert property (reg_wr && reg_addr == 8'h26 |=> $stable(decimation_setting))
    else $error("read-only write leaked");
  a_rd_unmapped: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_rd_setting: assert property (reg_rd && reg_addr == 8'h64 |=> reg_rdata == decimation_setting)
    else $error("setting read wrong");
  a_tick_needed: assert property ((ext_sample_en && !ext_sample_tick) [*4] |=> !sample_ready_pin)
    else $error("ready without a sample");
  c_ready: cover property (sample_ready_pin);
  c_read_high: cover property (reg_rd && reg_addr == 8'h26);
  c_set_write: cover property (reg_wr && reg_addr == 8'h64);
endmodule
bind davi_top davi_chk u_chk(.mclk(mclk), .nrst(nrst), .ext_sample_en(ext_sample_en),
  .ext_sample_tick(ext_sample_tick), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sample_ready_pin(sample_ready_pin), .decimation_setting(decimation_setting));
`default_nettype wire

// ==== tb/davi_host.sv ====
// Purpose: host model on the register port
// Assumes: data stands one cycle after the read strobe
// Notes: idle lines take inverted values so stale data shows
`timescale 1ns/1ns
`default_nettype none
module davi_host
(
  input wire logic mclk,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata
);
  // ==========
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 26'h0;
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge mclk);
    {reg_addr, reg_wdata, reg_wr} <= {~a, ~d, 1'b0};
  endtask
  task rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge mclk);
    {reg_addr, reg_rd} <= {~a, 1'b0};
    // data stands in the cycle after the strobe; take it at the closing edge
    @(posedge mclk);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_delta_angle_velocity_integrator.sv ====
// Purpose: self-checking bench for davi_top
// Assumes: external sample ticks after one internal-tick rate check
// Notes: results judged on whole clean periods
`timescale 1ns/1ns
`default_nettype none
`include "davi_map.vh"
module tb_delta_angle_velocity_integrator;
  logic mclk, nrst, tick, wr, rd, rdy, ext_en;
  logic [47:0] gyro, accel;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, dec;
  int fails = 0;
  int total_checks = 0;
  // ==========
  davi_top DUT(.mclk(mclk), .nrst(nrst), .ext_sample_en(ext_en), .ext_sample_tick(tick),
    .gyro_samples(gyro), .accel_samples(accel), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .sample_ready_pin(rdy),
    .decimation_setting(dec));
  davi_host host(.mclk(mclk), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdata));
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want)
    begin
      fails++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task conclude;
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // both halves read between two ready pulses
  task pair(input logic [7:0] a, input logic [31:0] want);
    logic [15:0] lo, hi;
    host.rd(a, lo);
    host.rd(a + 8'h02, hi);
    check({hi, lo}, want);
  endtask
  // ticks spaced six cycles until one ready pulse
  task period(output int n);
    logic seen;
    n = 0;
    seen = 1'b0;
    while (!seen && n < 20)
    begin
      @(posedge mclk) tick <= 1'b1;
      @(posedge mclk) tick <= 1'b0;
      repeat (4) @(posedge mclk) seen |= rdy;
      n++;
    end
  endtask
  // host-style rate measurement at decimation zero on the internal tick
  task internal_rate;
    int cnt;
    @(posedge mclk iff rdy);
    cnt = 0;
    do
    begin
      @(posedge mclk);
      cnt++;
    end
    while (!rdy);
    check(cnt, `DAVI_SAMPLE_CYC);
  endtask
  // third period is clean: old samples and old setting are flushed
  task integ(input int d, input int g, input int a);
    int n;
    host.wr(`DAVI_DEC_SET, d[15:0]);
    gyro <= {16'h0000, 16'(-g), 16'(g)};
    accel <= {16'(a), 16'h0000, 16'(-a)};
    repeat (3) period(n);
    check(n, d + 1);
    pair(`DAVI_X_ANG_LOW, (2 * g * (d + 1)) >>> 8);
    pair(`DAVI_Y_ANG_LOW, (-2 * g * (d + 1)) >>> 8);
    pair(`DAVI_Z_ANG_LOW, 0);
    pair(`DAVI_Z_VEL_LOW, (2 * a * (d + 1)) >>> 8);
    pair(`DAVI_X_VEL_LOW, (-2 * a * (d + 1)) >>> 8);
    host.wr(`DAVI_X_ANG_HIGH, 16'h5a5a);
    pair(`DAVI_X_ANG_LOW, (2 * g * (d + 1)) >>> 8);
  endtask
  initial
  begin
    {nrst, tick, gyro, accel} = 98'h0;
    ext_en = 1'b0;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    pair(`DAVI_X_ANG_LOW, 0);
    pair(8'h00, 0);
    check(dec, `DAVI_DEC_RST);
    internal_rate;
    ext_en <= 1'b1;
    integ(0, 128, 384);
    integ(1, 256, -128);
    integ(3, 32767, 32767);
    conclude;
  end
  // hang guard, well beyond the two internal sample periods plus register traffic
  initial
  begin
    #4000000;
    fails++;
    conclude;
  end
endmodule
`default_nettype wire
